// File: core/fpc_ctrl.sv
// Fan PWM sleep controller: time base, PWM, startup, shutdown, sleep, fault.
// Assumes comparator flags and level codes synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Time-base ticks step startup, sleep entry and sleep exit, and set the PWM period.
// - Duty follows the larger of primary and secondary control levels.
// - Level at 30% gives zero duty, 70% full duty, clamped outside.
// - Power-up reset happens on its own with no external action; the code resets only while rstn is held low.
// - Primary below shutdown threshold shuts down at once, any state.
// - In shutdown the drive is off and the fault is released.
// - Primary back above restart threshold resets as at power-up.
// - Every start from off forces drive high for 64 periods.
// - After power-up drive stays low, fault inactive, until startup.
// - After reset, fan starts only if an input exceeds the wake threshold.
// - Fault is active low open collector, set above overtemp threshold.
// - PWM keeps running normally while the fault is asserted.
// - Fault releases as soon as primary falls below the threshold.
// - Both inputs below sleep threshold enters sleep and stops the fan.
// - In sleep the drive is released and the fault inactive.
// - Sleep is left when an input exceeds the wake threshold, or by shutdown.
// - Sleep exit behaves as power-on reset with fresh startup.
// - Primary held low at least the minimum reset time guarantees reset.
module fpc_ctrl
   import fpc_pkg::*;
#(
   parameter int unsigned TB_CYCLES = FPC_TB_CYCLES,
   parameter int unsigned STARTUP_PERIODS = FPC_STARTUP_PERIODS
)
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [FPC_LVL_W-1:0] primary_control_input,
   input wire logic [FPC_LVL_W-1:0] secondary_control_input,
   input wire fpc_cmp_t cmp,
   output fpc_pins_t pins,
   output logic sleeping,
   output logic timebase_tick
);

   // ==========================================================
   // Level mapping
   // ==========================================================
   localparam logic [FPC_LVL_W-1:0] LVL_MIN =
      FPC_LVL_W'((FPC_LVL_FULL * FPC_MIN_PCT) / 100);
   localparam logic [FPC_LVL_W-1:0] LVL_MAX =
      FPC_LVL_W'((FPC_LVL_FULL * FPC_MAX_PCT) / 100);
   localparam int unsigned SPAN = FPC_LVL_FULL * (FPC_MAX_PCT - FPC_MIN_PCT) / 100;

   // Level to duty code 0..255, linear and clamped
   function automatic logic [7:0] fpc_duty(input logic [FPC_LVL_W-1:0] lvl);
      logic [15:0] num;
      logic [7:0] res;
      num = 16'h0000;
      res = 8'h00;
      if (lvl <= LVL_MIN)
      begin
         res = 8'h00;
      end
      else if (lvl >= LVL_MAX)
      begin
         res = 8'hff;
      end
      else
      begin
         num = 16'((lvl - LVL_MIN) * 255);
         res = 8'(num / 16'(SPAN));
      end
      return res;
   endfunction : fpc_duty

   logic [FPC_LVL_W-1:0] ctrl_lvl;
   logic [7:0] duty;

   always_comb
   begin
      if (primary_control_input > secondary_control_input)
      begin
         ctrl_lvl = primary_control_input;
      end
      else
      begin
         ctrl_lvl = secondary_control_input;
      end
      duty = fpc_duty(ctrl_lvl);
   end

   // ==========================================================
   // Time base
   // ==========================================================
   localparam int unsigned TRI_DIV = (TB_CYCLES / 256 > 0) ? TB_CYCLES / 256 : 1;
   logic [31:0] div_q;
   logic [7:0] tri_q;
   logic step;
   logic tri_wrap;

   // Divider steps the triangle counter, one full sweep per period
   assign step = (div_q == 32'(TRI_DIV - 1));
   assign tri_wrap = (tri_q == 8'hff);
   assign timebase_tick = step && tri_wrap;

   always_ff @(posedge core_clk)
   begin
      if (!rstn || step)
      begin
         div_q <= 32'h0000_0000;
      end
      else
      begin
         div_q <= div_q + 32'h0000_0001;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         tri_q <= FPC_TRI_RST;
      end
      else if (step)
      begin
         tri_q <= tri_q + 8'h01;
      end
   end

   // ==========================================================
   // Sequencer
   // ==========================================================
   fpc_state_t state_q, state_d;
   logic [6:0] start_cnt_q;
   logic any_wake;
   logic both_sleep;
   logic restart_ok;
   logic start_done;

   // Fan driven and fault reporting live
   function automatic logic fpc_live(input fpc_state_t st);
      return (st == FPC_ST_RUN) || (st == FPC_ST_STARTUP);
   endfunction : fpc_live

   assign any_wake = cmp.t1_above_wake || cmp.t2_above_wake;
   // Grounded sleep threshold makes both flags stay low
   assign both_sleep = cmp.t1_below_sleep && cmp.t2_below_sleep;
   assign restart_ok = cmp.above_restart && !cmp.below_shutdown;
   // Full count of ticks after entry, so never short of the interval
   assign start_done = timebase_tick && (start_cnt_q == 7'(STARTUP_PERIODS));

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         FPC_ST_SHUTDOWN:
         begin
            if (restart_ok)
            begin
               state_d = FPC_ST_WAIT_WAKE;
            end
         end
         FPC_ST_WAIT_WAKE:
         begin
            if (any_wake)
            begin
               state_d = FPC_ST_STARTUP;
            end
         end
         FPC_ST_STARTUP:
         begin
            if (start_done)
            begin
               state_d = FPC_ST_RUN;
            end
         end
         FPC_ST_RUN:
         begin
            if (both_sleep && timebase_tick)
            begin
               state_d = FPC_ST_SLEEP;
            end
         end
         FPC_ST_SLEEP:
         begin
            if (any_wake && timebase_tick)
            begin
               state_d = FPC_ST_STARTUP;
            end
         end
         default:
         begin
            state_d = FPC_ST_SHUTDOWN;
         end
      endcase
      if (cmp.below_shutdown)
      begin
         state_d = FPC_ST_SHUTDOWN;
      end
   end

   // ==========================================================
   // State register
   // ==========================================================
   // Reset lands in wait-for-wake, as at power-up
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         state_q <= FPC_ST_WAIT_WAKE;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // Cleared outside startup, so every entry counts from zero
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         start_cnt_q <= FPC_START_CNT_RST;
      end
      else if (state_q != FPC_ST_STARTUP)
      begin
         start_cnt_q <= FPC_START_CNT_RST;
      end
      else if (timebase_tick)
      begin
         start_cnt_q <= start_cnt_q + 7'h01;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   logic pwm_hi;
   logic drive_d, drive_q;
   logic drive_oe_d, drive_oe_q;
   logic fault_oe_d, fault_oe_q;

   assign pwm_hi = (duty == 8'hff) || (tri_q < duty);

   // Pin values follow the next state, so pins move with it
   always_comb
   begin
      drive_d = 1'b0;
      // Drive low in shutdown, released in sleep
      drive_oe_d = (state_d != FPC_ST_SLEEP);
      case (state_d)
         FPC_ST_STARTUP:
         begin
            drive_d = 1'b1;
         end
         FPC_ST_RUN:
         begin
            drive_d = pwm_hi;
         end
         default:
         begin
            drive_d = 1'b0;
         end
      endcase
   end

   // Fault masked in shutdown, sleep and wait
   always_comb
   begin
      fault_oe_d = cmp.above_overtemp && fpc_live(state_d);
   end

   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         drive_q <= 1'b0;
         drive_oe_q <= 1'b1;
      end
      else
      begin
         drive_q <= drive_d;
         drive_oe_q <= drive_oe_d;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         fault_oe_q <= 1'b0;
      end
      else
      begin
         fault_oe_q <= fault_oe_d;
      end
   end

   // ==========================================================
   // Pin assembly
   // ==========================================================
   // Open-drain fault pin only ever pulls low
   assign pins = '{drive_o: drive_q, drive_oe: drive_oe_q,
                   fault_n_o: 1'b0, fault_n_oe: fault_oe_q};
   assign sleeping = (state_q == FPC_ST_SLEEP);

endmodule : fpc_ctrl

`default_nettype wire

// File: inc/fpc_pkg.sv
// Fan PWM sleep controller package: states, constants, carrier structs.
// Assumes a single 100 MHz core clock domain.
package fpc_pkg;

   localparam int unsigned FPC_CLK_HZ = 100_000_000;
   localparam int unsigned FPC_TB_HZ = 30;
   localparam int unsigned FPC_TB_CYCLES = FPC_CLK_HZ / FPC_TB_HZ;
   localparam int unsigned FPC_STARTUP_PERIODS = 64;
   localparam int unsigned FPC_LVL_W = 8;
   localparam int unsigned FPC_LVL_FULL = 255;
   localparam int unsigned FPC_MIN_PCT = 30;
   localparam int unsigned FPC_MAX_PCT = 70;
   localparam int unsigned FPC_OT_MARGIN_PCT = 7;
   localparam int unsigned FPC_RESET_MIN_US = 30;
   localparam int unsigned FPC_RESET_MIN_CYC = (FPC_RESET_MIN_US * (FPC_CLK_HZ / 1_000_000));
   localparam logic [6:0] FPC_START_CNT_RST = 7'h00;
   localparam logic [7:0] FPC_TRI_RST = 8'h00;

   typedef enum {
      FPC_ST_SHUTDOWN,
      FPC_ST_WAIT_WAKE,
      FPC_ST_STARTUP,
      FPC_ST_RUN,
      FPC_ST_SLEEP
   } fpc_state_t;

   // Comparator flags from the analog front end
   typedef struct packed {
      logic below_shutdown;
      logic above_restart;
      logic t1_below_sleep;
      logic t2_below_sleep;
      logic t1_above_wake;
      logic t2_above_wake;
      logic above_overtemp;
   } fpc_cmp_t;

   // Pin drive set
   typedef struct packed {
      logic drive_o;
      logic drive_oe;
      logic fault_n_o;
      logic fault_n_oe;
   } fpc_pins_t;

endpackage : fpc_pkg

// File: testbench/fpc_chk.sv
// Port checker for fpc_ctrl.
// Assumes a bind to every fpc_ctrl instance.
`timescale 1ns/1ps
`default_nettype none
module fpc_chk
   import fpc_pkg::*;
#(parameter int unsigned TB_CYCLES = 512)
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire fpc_cmp_t cmp,
   input wire fpc_pins_t pins,
   input wire logic sleeping,
   input wire logic timebase_tick
);
   localparam int PER = TB_CYCLES / 256 * 256;
   int gap_q;
   logic ok_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // ========
   // Period tracking and assertions
   always_ff @(posedge core_clk)
   begin
      gap_q <= timebase_tick ? 1 : gap_q + 1;
      ok_q <= rstn && !cmp.below_shutdown && (ok_q || timebase_tick);
   end
   property p_shut; cmp.below_shutdown |=> !pins.drive_o && !pins.fault_n_oe; endproperty
   a_shut: assert property (p_shut) else $error("shutdown");
   property p_rst; $rose(rstn) |-> !pins.drive_o && !pins.fault_n_oe; endproperty
   a_rst: assert property (p_rst) else $error("reset");
   property p_flt_o; pins.fault_n_oe |-> !pins.fault_n_o; endproperty
   a_flt_o: assert property (p_flt_o) else $error("fault level");
   property p_flt_up; $rose(pins.fault_n_oe) |-> $past(cmp.above_overtemp); endproperty
   a_flt_up: assert property (p_flt_up) else $error("fault cause");
   property p_slp; sleeping && $past(sleeping) |-> !pins.drive_oe && !pins.fault_n_oe; endproperty
   a_slp: assert property (p_slp) else $error("sleep pins");
   property p_slp_in;
      $rose(sleeping) |-> $past(cmp.t1_below_sleep) && $past(cmp.t2_below_sleep);
   endproperty
   a_slp_in: assert property (p_slp_in) else $error("sleep entry");
   property p_wake; $fell(sleeping) |=> pins.drive_o [*8]; endproperty
   a_wake: assert property (p_wake) else $error("wake");
   property p_per; timebase_tick && ok_q |-> gap_q == PER; endproperty
   a_per: assert property (p_per) else $error("period");
endmodule : fpc_chk
bind fpc_ctrl fpc_chk #(.TB_CYCLES(TB_CYCLES)) u_fpc_chk (.core_clk(core_clk), .rstn(rstn),
   .cmp(cmp), .pins(pins), .sleeping(sleeping), .timebase_tick(timebase_tick));
`default_nettype wire

// File: testbench/fpc_fan_model.sv
// Thermistor comparators and fan drive transistor.
// Assumes level codes with 255 as full supply.
`timescale 1ns/1ps
`default_nettype none
module fpc_fan_model
   import fpc_pkg::*;
(
   input wire logic [7:0] t1,
   input wire logic [7:0] t2,
   input wire logic [7:0] slp,
   input wire fpc_pins_t pins,
   output var fpc_cmp_t cmp,
   output logic fan_on,
   output logic fault_line
);
   // ========
   // Comparators, wake hysteresis 28, overtemp 196
   assign cmp = {t1 < 8'h10, t1 > 8'h18, t1 < slp, t2 < slp, {1'b0, t1} > slp + 9'h01c,
      {1'b0, t2} > slp + 9'h01c, t1 > 8'hc4};
   assign fan_on = pins.drive_oe & pins.drive_o;
   assign fault_line = ~(pins.fault_n_oe & ~pins.fault_n_o);
endmodule : fpc_fan_model
`default_nettype wire

// File: testbench/tb_fan_pwm_sleep_controller.sv
// Bench for fpc_ctrl with fan and thermistor model.
// Assumes shortened time base and startup counts.
`timescale 1ns/1ps
`default_nettype none
module tb_fan_pwm_sleep_controller
   import fpc_pkg::*;
;
   localparam int TBC = 512;
   localparam int SUP = 4;
   localparam int LO = FPC_MIN_PCT * FPC_LVL_FULL / 100;
   localparam int HI = FPC_MAX_PCT * FPC_LVL_FULL / 100;
   localparam int OT = (FPC_MAX_PCT + FPC_OT_MARGIN_PCT) * FPC_LVL_FULL / 100;
   logic core_clk = 1'b0, rstn = 1'b0, sleeping, tick, fan_on, fault_line;
   logic [7:0] t1 = 8'h14, t2 = 8'h00, slp = 8'h00;
   fpc_cmp_t cmp;
   fpc_pins_t pins;
   int fails = 0, check_count = 0, n, i;
   always #5 core_clk = ~core_clk;
   fpc_ctrl #(.TB_CYCLES(TBC), .STARTUP_PERIODS(SUP)) u_fpc_ctrl (.core_clk(core_clk),
      .rstn(rstn), .primary_control_input(t1), .secondary_control_input(t2), .cmp(cmp),
      .pins(pins), .sleeping(sleeping), .timebase_tick(tick));
   fpc_fan_model u_fpc_fan_model (.t1(t1), .t2(t2), .slp(slp), .pins(pins), .cmp(cmp),
      .fan_on(fan_on), .fault_line(fault_line));
   // ========
   // Expectation, checking and waits
   function automatic int high(input logic [7:0] a, input logic [7:0] b);
      int l, d;
      l = a > b ? a : b;
      d = l <= LO ? 0 : l >= HI ? 255 : (l - LO) * 255 / (HI - LO);
      return d == 255 ? TBC : d * (TBC / 256);
   endfunction : high
   task automatic summarize();
      if (fails == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk
   task automatic quit();
      fails++;
      summarize();
   endtask : quit
   task automatic wait_tick();
      @(negedge core_clk);
      for (i = 0; i < 2 * TBC && tick !== 1'b1; i++)
         @(negedge core_clk);
      if (tick !== 1'b1)
         quit();
      @(posedge core_clk);
   endtask : wait_tick
   task automatic measure(input logic [7:0] a, input logic [7:0] b);
      t1 <= a;
      t2 <= b;
      wait_tick();
      wait_tick();
      n = 0;
      repeat (TBC)
      begin
         @(negedge core_clk);
         n += (fan_on === 1'b1);
      end
      chk(n, high(a, b));
      chk(fault_line, a <= OT);
      @(posedge core_clk);
   endtask : measure
   task automatic startup();
      for (i = 0; i < 2 * TBC && fan_on !== 1'b1; i++)
         @(negedge core_clk);
      if (fan_on !== 1'b1)
         quit();
      for (n = 0; n < 8 * TBC && fan_on === 1'b1; n++)
         @(negedge core_clk);
      chk(n >= SUP * TBC && n <= SUP * TBC + TBC + 64, 1);
      @(posedge core_clk);
   endtask : startup
   initial
   begin
      void'($urandom(32'hfc297ee6));
      repeat (16) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (TBC) @(posedge core_clk);
      @(negedge core_clk);
      chk(fan_on, 0);
      @(posedge core_clk);
      t1 <= 8'h4c;
      startup();
      measure(8'h4c, 8'h00);
      measure(8'hb2, 8'h00);
      measure(8'h64, 8'h96);
      for (int k = 0; k < 6; k++)
         measure(8'($urandom_range(255, 30)), 8'($urandom_range(255, 0)));
      measure(8'hdc, 8'h00);
      measure(8'h96, 8'h00);
      measure(8'hdc, 8'h00);
      t1 <= 8'h00;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      chk({fan_on, fault_line}, 2'b01);
      @(posedge core_clk);
      t1 <= 8'h4c;
      startup();
      slp <= 8'h32;
      t1 <= 8'h28;
      t2 <= 8'h1e;
      repeat (3) wait_tick();
      @(negedge core_clk);
      chk({sleeping, pins.drive_oe, fault_line}, 3'b101);
      @(posedge core_clk);
      t1 <= 8'h46;
      repeat (2) wait_tick();
      @(negedge core_clk);
      chk(sleeping, 1);
      @(posedge core_clk);
      t1 <= 8'h50;
      startup();
      summarize();
   end
endmodule : tb_fan_pwm_sleep_controller
`default_nettype wire
